// >>> sim/dpsd_master_model.sv
`timescale 1ns/1ps
// bus master stand-in: polls the slave and collects response frames
module dpsd_master_model (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic poll_i, // one-cycle poll from bench
	input wire logic slow_i, // ready only every other cycle
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_last_i,
	output logic master_req_o,
	output logic tx_ready_o,
	output logic [127:0] frame_o, // byte i at bits 8i+7:8i
	output logic [7:0] got_o // frames completed
);
	logic [3:0] idx_reg; // byte position
	logic [127:0] buf_reg; // frame being assembled
	// poll, take bytes, close frame on last
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			master_req_o <= 1'b0;
			tx_ready_o <= 1'b0;
			idx_reg <= 4'h0;
			got_o <= 8'h00;
		end else begin
			master_req_o <= poll_i;
			tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
			if (tx_valid_i && tx_ready_o) begin
				buf_reg[8*idx_reg +: 8] <= tx_data_i;
				idx_reg <= idx_reg + 4'h1;
				if (tx_last_i) begin
					frame_o <= {tx_data_i, buf_reg[119:0]};
					idx_reg <= 4'h0;
					got_o <= got_o + 8'h01;
				end
			end
		end
	end
endmodule : dpsd_master_model

// >>> sim/tb_dp_slave_diag_builder.sv
`timescale 1ns/1ps
module tb_dp_slave_diag_builder import dpsd_pkg::*;;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_valid = 1'b0, poll = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00, err_code = 8'h00, got, bas, g, k;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0001_27cb;
	logic pready, pslverr, pi_we, req, rdy, tx_valid, tx_last, er, avail;
	logic [7:0] pi_addr, pi_data, tx_data, mad;
	logic [127:0] frame, e;
	logic [23:0] flg; // station status bytes 0..2
	logic [15:0] idn;
	logic [39:0] pay; // user bytes 11..15
	logic [7:0] img [256]; // process image seen
	int pi_cnt = 0, c, checks = 0, fail_count = 0;
	// free running clock
	always #10 mclk_i = ~mclk_i;
	dpsd_diag_builder #(.PI_AW(8)) dpsd_diag_builder_inst (.mclk_i(mclk_i), .reset_i(reset_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pi_we_o(pi_we),
		.pi_addr_o(pi_addr), .pi_data_o(pi_data), .err_valid_i(err_valid), .err_code_i(err_code),
		.master_req_i(req), .diag_avail_o(avail), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
		.tx_last_o(tx_last), .tx_ready_i(rdy));
	dpsd_master_model dpsd_master_model_inst (.mclk_i(mclk_i), .reset_i(reset_i), .poll_i(poll),
		.slow_i(slow), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
		.master_req_o(req), .tx_ready_o(rdy), .frame_o(frame), .got_o(got));
	// image write monitor
	always @(posedge mclk_i) begin
		if (pi_we === 1'b1) begin
			img[pi_addr] <= pi_data;
			pi_cnt <= pi_cnt + 1;
		end
	end
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// expected response frame
	function automatic logic [127:0] exp_frame(input logic [7:0] code);
		return {pay, 24'h0, code, 8'h0a, idn[7:0], idn[15:8], mad, flg[23:16] & 8'h80,
			(flg[15:8] & 8'h3b) | 8'h04, flg[7:0] & 8'h5e};
	endfunction : exp_frame
	task check(input logic [127:0] seen, input logic [127:0] want, input string msg);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, want);
		end
	endtask : check
	// one apb transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fail_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd_chk(input logic [7:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h0);
		check({er, rd}, {1'b0, want}, "register read");
	endtask : rd_chk
	// wait for a new frame and compare it
	task wait_frame(input logic [7:0] code);
		int n;
		n = 0;
		g = got;
		while (got === g && n < 300) begin
			@(posedge mclk_i);
			n++;
		end
		if (got === g) fail_count++;
		@(posedge mclk_i);
		check(frame, exp_frame(code), "response frame");
	endtask : wait_frame
	// wait for six image writes and compare them
	task wait_img(input logic [7:0] st);
		int n;
		logic [47:0] s;
		n = 0;
		c = pi_cnt;
		while (pi_cnt < c + 6 && n < 100) begin
			@(posedge mclk_i);
			n++;
		end
		if (pi_cnt < c + 6) fail_count++;
		@(posedge mclk_i);
		for (int i = 0; i < 6; i++) s[8*i +: 8] = img[8'(bas + 8'(i))];
		check(128'(s), 128'({pay, st}), "image block");
	endtask : wait_img
	task wrap_up();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// hang guard
	initial begin
		#400000;
		fail_count++;
		wrap_up();
	end
	initial begin
		flg = 24'h0;
		repeat (12) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd_chk(DPSD_ADDR_STATUS, 32'h0);
		rd_chk(DPSD_ADDR_IDENT, 32'h00ff_0000);
		rd_chk(DPSD_ADDR_FLAGS, 32'h0000_0400);
		apb(1'b0, 8'h1c, 32'h0);
		check({er, rd}, {1'b1, 32'h0}, "unmapped read");
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			flg = 24'(rnd());
			idn = 16'(rnd());
			mad = 8'(rnd());
			pay = 40'({rnd(), rnd()});
			bas = 8'(rnd()) & 8'hf8;
			slow <= i[0];
			apb(1'b1, DPSD_ADDR_FLAGS, {8'h0, flg});
			apb(1'b1, DPSD_ADDR_IDENT, {8'h0, mad, idn});
			apb(1'b1, DPSD_ADDR_PAYLOAD_LO, pay[31:0]);
			apb(1'b1, DPSD_ADDR_PAYLOAD_HI, {24'h0, pay[39:32]});
			apb(1'b1, DPSD_ADDR_BASE, {24'h0, bas});
			rd_chk(DPSD_ADDR_IDENT, {8'h0, mad, idn});
			rd_chk(DPSD_ADDR_PAYLOAD_LO, pay[31:0]);
			rd_chk(DPSD_ADDR_PAYLOAD_HI, {24'h0, pay[39:32]});
			rd_chk(DPSD_ADDR_BASE, {24'h0, bas});
			e = exp_frame(8'h00);
			rd_chk(DPSD_ADDR_FLAGS, {8'h0, e[23:0]});
			apb(1'b1, DPSD_ADDR_STATUS, 32'h1);
			wait_img(8'h01);
			wait_frame(8'h40);
			rd_chk(DPSD_ADDR_STATE, 32'h40);
			apb(1'b1, DPSD_ADDR_STATUS, 32'h0);
		end
		$display("test user trigger done");
		c = pi_cnt;
		g = got;
		apb(1'b1, DPSD_ADDR_STATUS, 32'h3);
		repeat (30) @(posedge mclk_i);
		check(128'(pi_cnt), 128'(c), "image after 03");
		check(128'(got), 128'(g), "frames after 03");
		apb(1'b1, DPSD_ADDR_STATUS, 32'h0);
		$display("test ignore done");
		apb(1'b1, DPSD_ADDR_STATUS, 32'h1);
		wait_img(8'h01);
		wait_frame(8'h40);
		apb(1'b1, DPSD_ADDR_STATUS, 32'h2);
		rd_chk(DPSD_ADDR_STATE, 32'h0);
		poll <= 1'b1;
		@(posedge mclk_i);
		poll <= 1'b0;
		wait_frame(8'h00);
		$display("test delete done");
		for (k = DPSD_MSG_PRM_LEN; k <= DPSD_MSG_CMP; k++) begin
			err_code <= k;
			err_valid <= 1'b1;
			@(posedge mclk_i);
			err_valid <= 1'b0;
			@(posedge mclk_i);
			check(128'(avail), 128'(1), "report pending");
			wait_img(8'h02);
			wait_frame(k);
			check(128'(avail), 128'(0), "report cleared");
		end
		$display("test error codes done");
		wrap_up();
	end
endmodule : tb_dp_slave_diag_builder

// >>> src/dpsd_diag_builder.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// What this block does
// - byte 0: station status one flags
// - byte 1: status two, bit2 one
// - byte 2: bit7 overflow, rest zero
// - bytes 3-5: master address, ident high/low
// - header byte 6 is length 10, code 0
// - byte 7 carries the message code
// - bytes 11-15 carry user diagnostic data
// - event copies status plus payload, six bytes
// - copy base address is software programmable
// - status bit0 rising starts a diagnostic
// - status value 03h is stored but neither starts nor deletes
// - status bit0 marks user data valid
// - status bit1 deletes the diagnostic
// - image bytes 1-5 map to 11-15
// - answer requests, report errors unprompted
module dpsd_diag_builder import dpsd_pkg::*; #(
	parameter int PI_AW = 8
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// process image write port
	output logic pi_we_o,
	output logic [PI_AW-1:0] pi_addr_o,
	output logic [7:0] pi_data_o,
	// protocol-side error events
	input wire logic err_valid_i,
	input wire logic [7:0] err_code_i,
	// master side
	input wire logic master_req_i,
	output logic diag_avail_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input wire logic tx_ready_i
);
	// register decode, shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == DPSD_ADDR_STATUS) || (a == DPSD_ADDR_PAYLOAD_LO) ||
			(a == DPSD_ADDR_PAYLOAD_HI) || (a == DPSD_ADDR_FLAGS) ||
			(a == DPSD_ADDR_IDENT) || (a == DPSD_ADDR_BASE) || (a == DPSD_ADDR_STATE);
	endfunction : mapped

	logic [7:0] status_reg, status_next; // diagnostic trigger status
	logic [39:0] payload_reg, payload_next; // user diagnostic payload
	logic [23:0] flags_reg, flags_next; // station status bytes 0..2
	logic [15:0] ident_reg, ident_next; // ident number
	logic [7:0] maddr_reg, maddr_next; // parametrizing master
	logic [PI_AW-1:0] base_reg, base_next; // image block base
	logic [7:0] code_reg, code_next; // current message code
	logic pend_reg, pend_next; // unprompted report pending
	logic [31:0] prdata_reg, prdata_next;
	logic [47:0] snap_reg, snap_next; // status plus payload at event
	logic copy_busy_reg, copy_busy_next;
	logic [2:0] copy_idx_reg, copy_idx_next;
	logic pi_we_reg, pi_we_next;
	logic [PI_AW-1:0] pi_addr_reg, pi_addr_next;
	logic [7:0] pi_data_reg, pi_data_next;

	logic wr_en; // write takes effect
	logic setup; // apb setup cycle
	logic st_wr; // write to status
	logic [7:0] st_new; // status value written
	logic user_trig; // accepted 0->1 trigger
	logic user_del; // accepted delete
	logic tx_busy;
	logic tx_start;
	logic [8*DPSD_RESP_BYTES-1:0] frame;

	assign setup = psel_i && !penable_i;
	assign wr_en = psel_i && penable_i && pwrite_i && mapped(paddr_i);
	assign st_wr = wr_en && (paddr_i == DPSD_ADDR_STATUS);
	assign st_new = pwdata_i[7:0];
	assign user_trig = st_wr && (st_new != DPSD_ST_IGNORE) &&
		st_new[DPSD_ST_VALID] && !status_reg[DPSD_ST_VALID];
	assign user_del = st_wr && (st_new != DPSD_ST_IGNORE) && st_new[DPSD_ST_DELETE];

	// response frame assembly
	always_comb begin
		frame = '0;
		frame[0*8 +: 8] = flags_reg[7:0] & DPSD_B0_MASK;
		frame[1*8 +: 8] = (flags_reg[15:8] & DPSD_B1_MASK) | DPSD_B1_FIX1;
		frame[2*8 +: 8] = flags_reg[23:16] & DPSD_B2_MASK;
		frame[3*8 +: 8] = maddr_reg;
		frame[4*8 +: 8] = ident_reg[15:8];
		frame[5*8 +: 8] = ident_reg[7:0];
		frame[6*8 +: 8] = DPSD_HDR;
		frame[7*8 +: 8] = code_reg;
		frame[11*8 +: 40] = payload_reg;
	end

	// answer request or send pending report
	assign tx_start = !tx_busy && (master_req_i || pend_reg);

	// register file, trigger and copy sequencer next state
	always_comb begin
		status_next = status_reg;
		payload_next = payload_reg;
		flags_next = flags_reg;
		ident_next = ident_reg;
		maddr_next = maddr_reg;
		base_next = base_reg;
		code_next = code_reg;
		pend_next = pend_reg;
		prdata_next = prdata_reg;
		snap_next = snap_reg;
		copy_busy_next = copy_busy_reg;
		copy_idx_next = copy_idx_reg;
		pi_we_next = 1'b0;
		pi_addr_next = pi_addr_reg;
		pi_data_next = pi_data_reg;
		// read data captured in setup cycle
		if (setup && !pwrite_i) begin
			unique case (paddr_i)
				DPSD_ADDR_STATUS: prdata_next = {24'h00_0000, status_reg};
				DPSD_ADDR_PAYLOAD_LO: prdata_next = payload_reg[31:0];
				DPSD_ADDR_PAYLOAD_HI: prdata_next = {24'h00_0000, payload_reg[39:32]};
				DPSD_ADDR_FLAGS: prdata_next = {8'h00, frame[2*8 +: 8], frame[1*8 +: 8], frame[0*8 +: 8]};
				DPSD_ADDR_IDENT: prdata_next = {8'h00, maddr_reg, ident_reg};
				DPSD_ADDR_BASE: prdata_next = 32'(base_reg);
				DPSD_ADDR_STATE: prdata_next = {21'h00_0000, copy_busy_reg, tx_busy, pend_reg, code_reg};
				default: prdata_next = 32'h0000_0000;
			endcase
		end
		// writes
		if (wr_en) begin
			unique case (paddr_i)
				DPSD_ADDR_STATUS: status_next = st_new;
				DPSD_ADDR_PAYLOAD_LO: payload_next[31:0] = pwdata_i;
				DPSD_ADDR_PAYLOAD_HI: payload_next[39:32] = pwdata_i[7:0];
				DPSD_ADDR_FLAGS: flags_next = pwdata_i[23:0];
				DPSD_ADDR_IDENT: {maddr_next, ident_next} = pwdata_i[23:0];
				DPSD_ADDR_BASE: base_next = pwdata_i[PI_AW-1:0];
				default: ;
			endcase
		end
		// report sent clears pending
		if (tx_start) begin
			pend_next = 1'b0;
		end
		// delete withdraws the user diagnostic
		if (user_del && !user_trig) begin
			pend_next = 1'b0;
			if (code_reg == DPSD_MSG_USER) begin
				code_next = DPSD_MSG_NONE;
			end
		end
		if (user_trig) begin
			code_next = DPSD_MSG_USER;
			pend_next = 1'b1;
		end
		if (err_valid_i) begin
			code_next = err_code_i;
			pend_next = 1'b1;
		end
		if ((user_trig || err_valid_i) && !copy_busy_reg) begin
			snap_next = {payload_reg, user_trig ? st_new : status_reg};
			copy_busy_next = 1'b1;
			copy_idx_next = 3'h0;
		end else if (copy_busy_reg) begin
			pi_we_next = 1'b1;
			pi_addr_next = base_reg + PI_AW'(copy_idx_reg);
			pi_data_next = snap_reg[8*copy_idx_reg +: 8];
			if (copy_idx_reg == DPSD_BLOCK_LAST) begin
				copy_busy_next = 1'b0;
			end else begin
				copy_idx_next = copy_idx_reg + 3'h1;
			end
		end
	end

	// registers
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			status_reg <= DPSD_STATUS_RST;
			payload_reg <= DPSD_PAYLOAD_RST;
			flags_reg <= DPSD_FLAGS_RST;
			ident_reg <= DPSD_IDENT_RST;
			maddr_reg <= DPSD_MADDR_RST;
			base_reg <= '0;
			code_reg <= DPSD_MSG_NONE;
			pend_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			snap_reg <= '0;
			copy_busy_reg <= 1'b0;
			copy_idx_reg <= 3'h0;
			pi_we_reg <= 1'b0;
			pi_addr_reg <= '0;
			pi_data_reg <= 8'h00;
		end else begin
			status_reg <= status_next;
			payload_reg <= payload_next;
			flags_reg <= flags_next;
			ident_reg <= ident_next;
			maddr_reg <= maddr_next;
			base_reg <= base_next;
			code_reg <= code_next;
			pend_reg <= pend_next;
			prdata_reg <= prdata_next;
			snap_reg <= snap_next;
			copy_busy_reg <= copy_busy_next;
			copy_idx_reg <= copy_idx_next;
			pi_we_reg <= pi_we_next;
			pi_addr_reg <= pi_addr_next;
			pi_data_reg <= pi_data_next;
		end
	end

	// response serializer
	dpsd_tx #(.NBYTES(DPSD_RESP_BYTES)) u_tx (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.start_i(tx_start),
		.frame_i(frame),
		.busy_o(tx_busy),
		.tx_valid_o(tx_valid_o),
		.tx_data_o(tx_data_o),
		.tx_last_o(tx_last_o),
		.tx_ready_i(tx_ready_i)
	);

	// outputs
	assign prdata_o = prdata_reg;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);
	assign pi_we_o = pi_we_reg;
	assign pi_addr_o = pi_addr_reg;
	assign pi_data_o = pi_data_reg;
	assign diag_avail_o = pend_reg;

	// byte position seen at the stream output, lets the checks see sent bytes
	logic [3:0] out_pos_reg, out_pos_next;

	// position advances on each accepted byte
	always_comb begin
		out_pos_next = out_pos_reg;
		if (tx_valid_o && tx_ready_i) begin
			// last byte closes the frame, next one is byte 0
			out_pos_next = tx_last_o ? 4'h0 : out_pos_reg + 4'h1;
		end
	end

	// position register
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			out_pos_reg <= 4'h0;
		end else begin
			out_pos_reg <= out_pos_next;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	byte0_fixed_a: assert property (tx_valid_o && out_pos_reg == 4'h0 |-> (tx_data_o & 8'ha1) == 8'h00)
		else $error("byte 0 fixed bits not zero");
	byte1_fixed_a: assert property (tx_valid_o && out_pos_reg == 4'h1 |-> tx_data_o[2] && tx_data_o[7:6] == 2'b00)
		else $error("byte 1 fixed bits wrong");
	byte2_ovf_a: assert property (tx_valid_o && out_pos_reg == 4'h2 |-> tx_data_o[6:0] == 7'h00)
		else $error("byte 2 reserved bits not zero");
	ident_order_a: assert property (frame[47:24] == {ident_reg[7:0], ident_reg[15:8], maddr_reg})
		else $error("address or ident bytes wrong");
	header_len_a: assert property (tx_valid_o && out_pos_reg == 4'h6 |-> tx_data_o == 8'h0a)
		else $error("header byte wrong");
	frame_len_a: assert property (tx_valid_o && tx_last_o |-> out_pos_reg == 4'hf)
		else $error("frame not sixteen bytes");
	resv_zero_a: assert property (tx_valid_o && out_pos_reg >= 4'h8 && out_pos_reg <= 4'ha |-> tx_data_o == 8'h00)
		else $error("reserved byte not zero");
	user_code_a: assert property (user_trig && !err_valid_i |=> code_reg == 8'h40 && pend_reg)
		else $error("user trigger did not set code 40h");
	payload_map_a: assert property (frame[127:88] == payload_reg)
		else $error("user bytes not mapped");
	copy_len_a: assert property ($rose(copy_busy_reg) |-> copy_busy_reg [*6] ##1 !copy_busy_reg)
		else $error("image copy not six bytes");
	copy_base_a: assert property ($rose(pi_we_reg) |-> pi_addr_reg == $past(base_reg))
		else $error("image copy not at base");
	trig_rise_a: assert property (st_wr && st_new == 8'h01 && status_reg == 8'h00 && !copy_busy_reg
		|=> copy_busy_reg ##1 pi_we_reg && pi_data_reg == 8'h01)
		else $error("trigger did not start copy");
	ignore_03_a: assert property (st_wr && st_new == 8'h03 && !err_valid_i && !pend_reg
		|=> !pend_reg)
		else $error("status 03h not ignored");
	delete_clr_a: assert property (user_del && !user_trig && !err_valid_i |=> !pend_reg)
		else $error("delete left report pending");
	req_answer_a: assert property (master_req_i && !tx_busy |=> tx_valid_o && tx_data_o == $past(frame[7:0]))
		else $error("request not answered");
endmodule : dpsd_diag_builder

// >>> src/dpsd_pkg.sv
package dpsd_pkg;
	// printed register indices, byte address is four times the index
	localparam logic [7:0] DPSD_IDX_STATUS = 8'h00;
	localparam logic [7:0] DPSD_IDX_PAYLOAD = 8'h01;
	localparam logic [7:0] DPSD_ADDR_STATUS = {DPSD_IDX_STATUS[5:0], 2'b00};
	localparam logic [7:0] DPSD_ADDR_PAYLOAD_LO = {DPSD_IDX_PAYLOAD[5:0], 2'b00};
	// further registers of the block
	localparam logic [7:0] DPSD_ADDR_PAYLOAD_HI = 8'h08;
	localparam logic [7:0] DPSD_ADDR_FLAGS = 8'h0c;
	localparam logic [7:0] DPSD_ADDR_IDENT = 8'h10;
	localparam logic [7:0] DPSD_ADDR_BASE = 8'h14;
	localparam logic [7:0] DPSD_ADDR_STATE = 8'h18;
	// frame geometry
	localparam int DPSD_RESP_BYTES = 16;
	localparam int DPSD_BLOCK_BYTES = 6;
	localparam logic [2:0] DPSD_BLOCK_LAST = 3'h5;
	// station status masks and fixed bits
	localparam logic [7:0] DPSD_B0_MASK = 8'h5e;
	localparam logic [7:0] DPSD_B1_MASK = 8'h3b;
	localparam logic [7:0] DPSD_B1_FIX1 = 8'h04;
	localparam logic [7:0] DPSD_B2_MASK = 8'h80;
	// header: length 001010, code 00
	localparam logic [7:0] DPSD_HDR = 8'h0a;
	// message codes
	localparam logic [7:0] DPSD_MSG_NONE = 8'h00;
	localparam logic [7:0] DPSD_MSG_PRM_LEN = 8'h12;
	localparam logic [7:0] DPSD_MSG_CFG_LEN = 8'h13;
	localparam logic [7:0] DPSD_MSG_CFG_ENTRY = 8'h14;
	localparam logic [7:0] DPSD_MSG_BUF_CALC = 8'h15;
	localparam logic [7:0] DPSD_MSG_CFG_MISS = 8'h16;
	localparam logic [7:0] DPSD_MSG_CMP = 8'h17;
	localparam logic [7:0] DPSD_MSG_USER = 8'h40;
	// status byte fields
	localparam int DPSD_ST_VALID = 0;
	localparam int DPSD_ST_DELETE = 1;
	localparam logic [7:0] DPSD_ST_IGNORE = 8'h03;
	// reset values
	localparam logic [7:0] DPSD_STATUS_RST = 8'h00;
	localparam logic [39:0] DPSD_PAYLOAD_RST = 40'h00_0000_0000;
	localparam logic [23:0] DPSD_FLAGS_RST = 24'h00_0000;
	localparam logic [7:0] DPSD_MADDR_RST = 8'hff;
	localparam logic [15:0] DPSD_IDENT_RST = 16'h0000;
endpackage : dpsd_pkg

// >>> src/dpsd_tx.sv
`timescale 1ns/1ps
// streams a latched response frame byte by byte, byte 0 first
module dpsd_tx import dpsd_pkg::*; #(
	parameter int NBYTES = DPSD_RESP_BYTES
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire logic [8*NBYTES-1:0] frame_i,
	output logic busy_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input wire logic tx_ready_i
);
	localparam int IW = $clog2(NBYTES);
	localparam logic [IW-1:0] LAST = IW'(NBYTES - 1);

	logic [8*NBYTES-1:0] shadow_reg, shadow_next; // frame held stable while sent
	logic [IW-1:0] idx_reg, idx_next; // byte in flight
	logic valid_reg, valid_next;
	logic [7:0] data_reg, data_next;

	// next-state for the byte stream
	always_comb begin
		shadow_next = shadow_reg;
		idx_next = idx_reg;
		valid_next = valid_reg;
		data_next = data_reg;
		if (start_i && !valid_reg) begin
			// latch frame, present byte 0
			shadow_next = frame_i;
			idx_next = '0;
			valid_next = 1'b1;
			data_next = frame_i[7:0];
		end else if (valid_reg && tx_ready_i) begin
			if (idx_reg == LAST) begin
				valid_next = 1'b0;
			end else begin
				idx_next = idx_reg + 1'b1;
				data_next = shadow_reg[8*(idx_reg+1'b1) +: 8];
			end
		end
	end

	// registers
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			shadow_reg <= '0;
			idx_reg <= '0;
			valid_reg <= 1'b0;
			data_reg <= 8'h00;
		end else begin
			shadow_reg <= shadow_next;
			idx_reg <= idx_next;
			valid_reg <= valid_next;
			data_reg <= data_next;
		end
	end

	assign busy_o = valid_reg;
	assign tx_valid_o = valid_reg;
	assign tx_data_o = data_reg;
	assign tx_last_o = valid_reg && (idx_reg == LAST);
endmodule : dpsd_tx
